// >>> design/pcm_frame_mode_control.sv
// Purpose: Framing, mode control and data port of a serial audio interface
// Assumes: Pins come from another clock domain; APB on CLK
// Notes: Two channels of CH_WIDTH bits at frame positions 0 and CH_WIDTH
//
// Functional notes
// [RULE1] Clearing receive enable stops reception at the next frame end; with density filter enable, decimation stops at the next sample edge.
// [RULE2] Setting receive enable starts reception at the next frame start; with density filter enable, decimation starts at the next sample edge.
// [RULE3] Enable bits may be written at any time, even while running.
// [RULE4] Interface enable low disables and idles the whole interface.
// [RULE5] One data port: writes queue transmit words, reads pop received ones.
// [RULE6] Software changes the mode register only while stopped.
// [RULE7] Bit clock gate stops the bit clock cleanly, without glitches.
// [RULE8] Decimation select: 0 gives factor 16, 1 gives factor 32.
// [RULE9] Density filter enable routes the data pin through the decimator.
// [RULE10] Receive packed: two channels in one word, first in low half.
// [RULE11] Transmit packed: one word split into halves, low half first.
// [RULE12] Bit clock is driven as output unless bit clock slave is set.
// [RULE13] Invert low: drive on rising, sample on falling; set swaps them.
// [RULE14] Sync master drives the sync pin; sync slave locks to it.
// [RULE15] Sync master idles inactive and pulses active, polarity by invert.
// [RULE16] Sync slave starts a frame when sync goes inactive to active.
// [RULE17] Generated frame lasts frame_length plus one bit clocks.
// [RULE18] Sync pulse width in clocks; zero none; at least length permanent.
// [RULE19] Reserved mode bits 31:29 are written as zero.
// [RULE20] Frame counter runs whenever transmit or receive is enabled.
// [RULE21] Transmission starts at next frame start with the first channel.
`timescale 1ns/1ps
`default_nettype none
module pcm_frame_mode_control
    import pcm_frame_pkg::*;
#(
    parameter int FIFO_DEPTH = 64,
    parameter int CH_WIDTH = 16,
    parameter int BCLK_HALF = BCLK_HALF_CYCLES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Bit clock pin
    input wire logic BIT_CLK_LEVEL,
    output logic BIT_CLK_DRIVE,
    output logic BIT_CLK_OE,
    // Frame sync pin
    input wire logic FRAME_SYNC_PIN_LEVEL,
    output logic FRAME_SYNC_PIN_DRIVE,
    output logic FRAME_SYNC_PIN_OE,
    // Serial data pins
    input wire logic SDATA_RECEIVE,
    output logic SDATA_SEND
);
    if (CH_WIDTH < 1 || CH_WIDTH > 32 || BCLK_HALF < 2 || BCLK_HALF > 256)
    begin : g_bad_param
        $error("pcm_frame_mode_control: unsupported parameter value");
    end

    localparam logic [9:0] CH0_END = 10'(CH_WIDTH - 1);
    localparam logic [9:0] CH1_START = 10'(CH_WIDTH);
    localparam logic [9:0] CH1_END = 10'(2 * CH_WIDTH - 1);
    localparam logic [31:0] CH_MASK = 32'hFFFFFFFF >> (32 - CH_WIDTH);

    // Places the low CH_WIDTH bits at the top, ready to shift out MSB first
    function automatic logic [31:0] align(input logic [31:0] v);
        return v << (32 - CH_WIDTH);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers and APB slave
    logic [2:0] ctrl_q, ctrl_d;
    logic [31:0] mode_q, mode_d, prdata_q, prdata_d;
    logic apb_wr, apb_rd, hit;
    logic tx_push, tx_pop, tx_empty, tx_full;
    logic rx_push, rx_pop, rx_empty;
    logic [31:0] tx_head, rx_head, rx_word;

    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_rd = PSEL && PENABLE && !PWRITE;
    assign hit = PADDR == ADDR_CTRL || PADDR == ADDR_DATA
              || PADDR == ADDR_MODE;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit;
    assign PRDATA = prdata_q;
    assign tx_push = apb_wr && PADDR == ADDR_DATA; // [RULE5]
    assign rx_pop = apb_rd && PADDR == ADDR_DATA; // [RULE5]

    always_comb begin
        ctrl_d = ctrl_q;
        mode_d = mode_q;
        prdata_d = prdata_q;
        if (apb_wr && PADDR == ADDR_CTRL) begin
            ctrl_d = PWDATA[2:0]; // [RULE3]
        end else if (apb_wr && PADDR == ADDR_MODE) begin
            mode_d = PWDATA & MODE_WMASK;
        end
        if (PSEL && !PENABLE) begin
            prdata_d = 32'h00000000;
            if (PADDR == ADDR_CTRL) begin
                prdata_d[2:0] = ctrl_q;
                prdata_d[STAT_TXE_BIT] = tx_empty;
                prdata_d[STAT_RXD_BIT] = !rx_empty;
                prdata_d[STAT_TXD_BIT] = !tx_full;
            end else if (PADDR == ADDR_DATA) begin
                prdata_d = rx_empty ? 32'h00000000 : rx_head; // [RULE5]
            end else if (PADDR == ADDR_MODE) begin
                prdata_d = mode_q;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_q <= CTRL_RESET;
            mode_q <= MODE_RESET;
            prdata_q <= 32'h00000000;
        end else begin
            ctrl_q <= ctrl_d;
            mode_q <= mode_d;
            prdata_q <= prdata_d;
        end
    end

    logic en, receive_enable, transmit_enable, gate, dec32, pdm, rxp, txp, clk_slv, clk_inv;
    logic fs_slv, fs_inv;
    logic [9:0] frame_length, sync_pulse_width;
    assign en = ctrl_q[CTRL_EN_BIT];
    assign receive_enable = ctrl_q[CTRL_RECEIVE_ENABLE_BIT];
    assign transmit_enable = ctrl_q[CTRL_TRANSMIT_ENABLE_BIT];
    assign gate = mode_q[MODE_GATE_BIT];
    assign dec32 = mode_q[MODE_DEC_BIT];
    assign pdm = mode_q[MODE_PDM_BIT];
    assign rxp = mode_q[MODE_RXP_BIT];
    assign txp = mode_q[MODE_TXP_BIT];
    assign clk_slv = mode_q[MODE_BIT_CLOCK_SLAVE_BIT];
    assign clk_inv = mode_q[MODE_BIT_CLOCK_INVERT_BIT];
    assign fs_slv = mode_q[MODE_FSM_BIT];
    assign fs_inv = mode_q[MODE_FSI_BIT];
    assign frame_length = mode_q[MODE_FRAME_LENGTH_LSB +: LEN_FIELD_W];
    assign sync_pulse_width = mode_q[MODE_SYNC_PULSE_WIDTH_LSB +: LEN_FIELD_W];

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: bit clock, sync, data
    logic [2:0] sync1_q, sync2_q, sync3_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            sync3_q <= 3'h0;
        end else begin
            sync1_q <= {BIT_CLK_LEVEL, FRAME_SYNC_PIN_LEVEL, SDATA_RECEIVE};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit clock generation and edge detection
    logic [7:0] bdiv_q, bdiv_d;
    logic bclk_q, bclk_d, tick, rise, fall, drive_edge, sample_edge;

    assign tick = en && !clk_slv && bdiv_q == 8'(BCLK_HALF - 1);
    assign rise = clk_slv ? en && !gate && sync2_q[2] && !sync3_q[2]
                          : tick && !bclk_q && !gate; // [RULE7]
    assign fall = clk_slv ? en && !gate && !sync2_q[2] && sync3_q[2]
                          : tick && bclk_q;
    assign drive_edge = clk_inv ? fall : rise; // [RULE13]
    assign sample_edge = clk_inv ? rise : fall; // [RULE13]

    always_comb begin
        bdiv_d = bdiv_q + 8'h01;
        bclk_d = bclk_q;
        if (!en || clk_slv) begin
            bdiv_d = 8'h00; // [RULE4]
            bclk_d = 1'b0;
        end else if (tick) begin
            bdiv_d = 8'h00;
            bclk_d = rise || fall ? !bclk_q : bclk_q; // [RULE7]
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bdiv_q <= 8'h00;
            bclk_q <= 1'b0;
        end else begin
            bdiv_q <= bdiv_d;
            bclk_q <= bclk_d;
        end
    end

    assign BIT_CLK_DRIVE = bclk_q;
    assign BIT_CLK_OE = en && !clk_slv; // [RULE12]

    ////////////////////////////////////////////////////////////////////////
    // Frame counter and sync
    logic [9:0] cnt_q, cnt_d;
    logic started_q, started_d, pend_q, pend_d, fsprev_q, fsprev_d;
    logic fso_q, fso_d, run, fs_act, fstart;
    logic tx_on_q, rx_on_q;

    assign run = en && (transmit_enable || receive_enable || tx_on_q || rx_on_q); // [RULE20]
    assign fs_act = sync2_q[1] ^ fs_inv; // [RULE16]
    assign fstart = run && drive_edge
                 && (fs_slv ? pend_q : !started_q || cnt_q >= frame_length); // [RULE17]

    always_comb begin
        cnt_d = cnt_q;
        started_d = started_q;
        pend_d = pend_q;
        fsprev_d = fsprev_q;
        if (!run) begin
            cnt_d = 10'h000;
            started_d = 1'b0;
            pend_d = 1'b0;
        end else begin
            if (fs_slv && sample_edge) begin
                fsprev_d = fs_act;
                if (fs_act && !fsprev_q) begin
                    pend_d = 1'b1; // [RULE16]
                end
            end
            if (fstart) begin
                cnt_d = 10'h000;
                started_d = 1'b1;
                pend_d = 1'b0;
            end else if (drive_edge && started_q && cnt_q != 10'h3FF) begin
                cnt_d = cnt_q + 10'h001;
            end
        end
        fso_d = 1'b0;
        if (run && started_d && sync_pulse_width != 10'h000) begin
            fso_d = cnt_d < sync_pulse_width || sync_pulse_width >= frame_length; // [RULE18]
        end
        fso_d = fso_d ^ fs_inv; // [RULE15]
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cnt_q <= 10'h000;
            started_q <= 1'b0;
            pend_q <= 1'b0;
            fsprev_q <= 1'b1;
            fso_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            started_q <= started_d;
            pend_q <= pend_d;
            fsprev_q <= fsprev_d;
            fso_q <= fso_d;
        end
    end

    assign FRAME_SYNC_PIN_DRIVE = fso_q;
    assign FRAME_SYNC_PIN_OE = en && !fs_slv; // [RULE14]

    ////////////////////////////////////////////////////////////////////////
    // Transmit path
    logic tx_on_d, dout_q, dout_d;
    logic [31:0] tx_sh_q, tx_sh_d;
    logic [15:0] hold_q, hold_d;
    logic [31:0] tx_word;

    assign tx_word = tx_empty ? 32'h00000000 : tx_head;

    always_comb begin
        tx_on_d = tx_on_q;
        tx_sh_d = tx_sh_q;
        hold_d = hold_q;
        dout_d = dout_q;
        tx_pop = 1'b0;
        if (!run) begin
            tx_on_d = 1'b0;
            dout_d = 1'b0;
        end else if (drive_edge) begin
            if (fstart) begin
                tx_on_d = transmit_enable; // [RULE21]
            end
            tx_sh_d = {tx_sh_q[30:0], 1'b0};
            if (tx_on_d && started_d && cnt_d == 10'h000) begin
                tx_pop = 1'b1; // [RULE21]
                tx_sh_d = align(txp ? {16'h0000, tx_word[15:0]} : tx_word);
                hold_d = tx_word[31:16]; // [RULE11]
            end else if (tx_on_d && started_d && cnt_d == CH1_START) begin
                tx_pop = !txp;
                tx_sh_d = align(txp ? {16'h0000, hold_q} : tx_word); // [RULE11]
            end
            dout_d = tx_on_d && started_d && cnt_d <= CH1_END && tx_sh_d[31];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_on_q <= 1'b0;
            tx_sh_q <= 32'h00000000;
            hold_q <= 16'h0000;
            dout_q <= 1'b0;
        end else begin
            tx_on_q <= tx_on_d;
            tx_sh_q <= tx_sh_d;
            hold_q <= hold_d;
            dout_q <= dout_d;
        end
    end

    assign SDATA_SEND = dout_q;

    ////////////////////////////////////////////////////////////////////////
    // Receive path and density decimator
    logic rx_on_d;
    logic [31:0] rx_sh_q, rx_sh_d;
    logic [15:0] rx_lo_q, rx_lo_d;
    logic [4:0] dec_q, dec_d;
    logic [5:0] acc_q, acc_d;
    logic din;

    assign din = sync2_q[0];

    always_comb begin
        rx_on_d = rx_on_q;
        rx_sh_d = rx_sh_q;
        rx_lo_d = rx_lo_q;
        dec_d = dec_q;
        acc_d = acc_q;
        rx_push = 1'b0;
        rx_word = 32'h00000000;
        if (!run) begin
            rx_on_d = 1'b0; // [RULE4]
            dec_d = 5'h00;
            acc_d = 6'h00;
        end else begin
            if (fstart) begin
                rx_on_d = receive_enable; // [RULE1] [RULE2]
            end
            if (pdm && receive_enable && sample_edge) begin
                acc_d = acc_q + {5'h00, din}; // [RULE9]
                dec_d = dec_q + 5'h01;
                if (dec_q == (dec32 ? 5'(DEC_LONG - 1)
                                    : 5'(DEC_SHORT - 1))) begin // [RULE8]
                    rx_push = 1'b1;
                    rx_word = {26'h0000000, acc_d};
                    acc_d = 6'h00;
                    dec_d = 5'h00;
                end
            end else if (!pdm && rx_on_q && started_q && sample_edge
                         && cnt_q <= CH1_END) begin
                rx_sh_d = {rx_sh_q[30:0], din};
                if (cnt_q == CH0_END) begin
                    rx_lo_d = rx_sh_d[15:0]; // [RULE10]
                    rx_push = !rxp;
                    rx_word = rx_sh_d & CH_MASK;
                end else if (cnt_q == CH1_END) begin
                    rx_push = 1'b1;
                    rx_word = rxp ? {rx_sh_d[15:0], rx_lo_q}
                                  : rx_sh_d & CH_MASK; // [RULE10]
                end
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_on_q <= 1'b0;
            rx_sh_q <= 32'h00000000;
            rx_lo_q <= 16'h0000;
            dec_q <= 5'h00;
            acc_q <= 6'h00;
        end else begin
            rx_on_q <= rx_on_d;
            rx_sh_q <= rx_sh_d;
            rx_lo_q <= rx_lo_d;
            dec_q <= dec_d;
            acc_q <= acc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Queues
    pcm_word_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk(CLK), .rst(RST), .push(tx_push), .push_data(PWDATA),
        .pop(tx_pop), .head_q(tx_head), .empty(tx_empty), .full(tx_full)
    );
    pcm_word_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk(CLK), .rst(RST), .push(rx_push), .push_data(rx_word),
        .pop(rx_pop), .head_q(rx_head), .empty(rx_empty), .full()
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    property p_ctrl_write;
        apb_wr && PADDR == ADDR_CTRL |=> ctrl_q == $past(PWDATA[2:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) // [RULE3]
        else $error("control write not taken");

    property p_disable_idle;
        !en |=> !bclk_q && cnt_q == 10'h000 && !tx_on_q && !rx_on_q;
    endproperty
    a_disable_idle: assert property (p_disable_idle) // [RULE4]
        else $error("disabled interface not idle");

    property p_data_write;
        tx_push && tx_empty |=> !tx_empty;
    endproperty
    a_data_write: assert property (p_data_write) // [RULE5]
        else $error("data port write not queued");

    property p_gate_holds;
        en && !clk_slv && gate && !bclk_q |=> !bclk_q;
    endproperty
    a_gate_holds: assert property (p_gate_holds) // [RULE7]
        else $error("gated bit clock rose");

    property p_rx_start;
        $rose(rx_on_q) |-> $past(fstart) && $past(receive_enable);
    endproperty
    a_rx_start: assert property (p_rx_start) // [RULE2]
        else $error("reception began outside frame start");

    property p_rx_stop;
        $fell(rx_on_q) |-> $past(fstart) || !$past(run);
    endproperty
    a_rx_stop: assert property (p_rx_stop) // [RULE1]
        else $error("reception stopped mid frame");

    property p_tx_start;
        $rose(tx_on_q) |-> $past(fstart) && $past(transmit_enable);
    endproperty
    a_tx_start: assert property (p_tx_start) // [RULE21]
        else $error("transmission began outside frame start");

    property p_frame_wrap;
        run && !fs_slv && drive_edge && started_q && cnt_q == frame_length
            |=> cnt_q == 10'h000;
    endproperty
    a_frame_wrap: assert property (p_frame_wrap) // [RULE17]
        else $error("frame length wrong");

    property p_no_pulse;
        $past(sync_pulse_width) == 10'h000 |-> FRAME_SYNC_PIN_DRIVE == $past(fs_inv);
    endproperty
    a_no_pulse: assert property (p_no_pulse) // [RULE18]
        else $error("sync pulse with zero width");

    property p_slave_edge;
        run && fs_slv && sample_edge && fs_act && !fsprev_q && !fstart
            |=> pend_q;
    endproperty
    a_slave_edge: assert property (p_slave_edge) // [RULE16]
        else $error("sync slave missed active edge");

    property p_packed_rx;
        rx_push && rxp && !pdm |-> rx_word[15:0] == rx_lo_q;
    endproperty
    a_packed_rx: assert property (p_packed_rx) // [RULE10]
        else $error("packed word low half is not first channel");
endmodule
`default_nettype wire

// >>> design/pcm_frame_pkg.sv
// Purpose: Shared constants for the serial audio framing block
// Assumes: 250 MHz system clock, 32-bit APB register bus
// Notes: Offsets are byte addresses of aligned 32-bit words
package pcm_frame_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DATA = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;

    // Control and status word
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_RECEIVE_ENABLE_BIT = 1;
    localparam int CTRL_TRANSMIT_ENABLE_BIT = 2;
    localparam int STAT_TXD_BIT = 19;
    localparam int STAT_RXD_BIT = 20;
    localparam int STAT_TXE_BIT = 21;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Operating mode word
    localparam int MODE_GATE_BIT = 28;
    localparam int MODE_DEC_BIT = 27;
    localparam int MODE_PDM_BIT = 26;
    localparam int MODE_RXP_BIT = 25;
    localparam int MODE_TXP_BIT = 24;
    localparam int MODE_BIT_CLOCK_SLAVE_BIT = 23;
    localparam int MODE_BIT_CLOCK_INVERT_BIT = 22;
    localparam int MODE_FSM_BIT = 21;
    localparam int MODE_FSI_BIT = 20;
    localparam int MODE_FRAME_LENGTH_LSB = 10;
    localparam int MODE_SYNC_PULSE_WIDTH_LSB = 0;
    localparam int LEN_FIELD_W = 10;
    localparam logic [31:0] MODE_WMASK = 32'h1FFFFFFF;
    localparam logic [31:0] MODE_RESET = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_FREQ_MHZ = 250;
    localparam int BCLK_PERIOD_NS = 32;
    localparam int BCLK_HALF_CYCLES = BCLK_PERIOD_NS * CLK_FREQ_MHZ / 2000;

    // Density input decimation factors
    localparam int DEC_SHORT = 16;
    localparam int DEC_LONG = 32;

endpackage

// >>> design/pcm_word_fifo.sv
// Purpose: Small word queue with registered head output
// Assumes: Pop is ignored when empty and push is ignored when full
// Notes: Head register follows each push and pop on the same edge
`timescale 1ns/1ps
`default_nettype none
module pcm_word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    // Drain side
    input wire logic pop,
    output logic [WIDTH-1:0] head_q,
    output logic empty,
    output logic full
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("pcm_word_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [AW:0] count_q, count_d;
    logic [WIDTH-1:0] head_d;
    logic do_push, do_pop;

    assign empty = (count_q == '0);
    assign full = (count_q == (AW+1)'(DEPTH));
    assign do_push = push && !full;
    assign do_pop = pop && !empty;

    always_comb begin
        wr_ptr_d = do_push ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d = do_pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
        // Forward a word pushed into the slot that becomes the head
        head_d = mem[rd_ptr_d];
        if (do_push && wr_ptr_q == rd_ptr_d) begin
            head_d = push_data;
        end
        count_d = count_q;
        if (do_push && !do_pop) begin
            count_d = count_q + 1'b1;
        end else if (do_pop && !do_push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            head_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            head_q <= head_d;
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_q] <= push_data;
        end
    end
endmodule
`default_nettype wire

// >>> sim/codec_model.sv
// Purpose: Audio codec model on the serial pins
// Assumes: It makes bit clock and sync only while run is high
// Notes: Echoes the sent data straight back to the receive pin
`timescale 1ns/1ps
`default_nettype none
module codec_model (
    // Control
    input wire logic run,
    // Serial pins
    output logic bclk,
    output logic fsync,
    input wire logic sdo,
    output logic sdi
);
    int cnt = 0;
    initial bclk = 1'b0;
    // Clock stands still between runs, 32 ns period
    always begin
        #16;
        if (run) begin
            bclk = ~bclk;
        end
    end
    always @(posedge bclk) begin
        cnt <= (cnt == 31) ? 0 : cnt + 1;
    end
    assign fsync = (cnt == 0);
    assign sdi = sdo;
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Purpose: Self-checking bench for the framing and mode block
// Assumes: Codec model echoes serial data back
// Notes: Sync timing is counted over whole frames
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pcm_frame_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, bclk_drv, bclk_oe, fs_drv, fs_oe, sdo, err;
    logic cod_run = 1'b0;
    wire logic cod_bclk, cod_fs, sdi;
    wire logic bclk_w = bclk_oe ? bclk_drv : cod_bclk;
    wire logic fs_w = fs_oe ? fs_drv : cod_fs;
    int n_fail = 0;
    int num_checks = 0;
    int on, rise, per, frame_length, sync_pulse_width, e_on, e_rise;
    logic [31:0] modes [5] = '{32'h00007C01, 32'h00107C03, 32'h00003C01,
                               32'h00007C00, 32'h00107C20};
    always #2 clk = ~clk;
    pcm_frame_mode_control i_pcm_frame_mode_control (.CLK(clk), .RST(rst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .BIT_CLK_LEVEL(bclk_w), .BIT_CLK_DRIVE(bclk_drv),
        .BIT_CLK_OE(bclk_oe), .FRAME_SYNC_PIN_LEVEL(fs_w),
        .FRAME_SYNC_PIN_DRIVE(fs_drv), .FRAME_SYNC_PIN_OE(fs_oe),
        .SDATA_RECEIVE(sdi), .SDATA_SEND(sdo));
    codec_model i_codec_model (.run(cod_run), .bclk(cod_bclk),
        .fsync(cod_fs), .sdo(sdo), .sdi(sdi));
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(nm, e, r);
    endtask
    task automatic count_sync(input logic act);
        logic prev;
        on = 0;
        rise = 0;
        prev = fs_w;
        repeat (1024) begin
            @(posedge clk);
            on += (fs_w === act);
            rise += (fs_w === act && prev !== act);
            prev = fs_w;
        end
    endtask
    task automatic count_clk;
        on = 0;
        repeat (64) begin
            @(posedge clk);
            on += (bclk_drv === 1'b1);
        end
    endtask
    task automatic echo(input logic [31:0] m, w0, w1, input logic slv);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        cod_run <= slv;
        wr(ADDR_MODE, m);
        wr(ADDR_DATA, w0);
        wr(ADDR_DATA, w1);
        wr(ADDR_CTRL, 32'h7);
        repeat (800) @(posedge clk);
        wr(ADDR_CTRL, 32'h1);
        repeat (600) @(posedge clk);
        rd(ADDR_DATA, w0, "echo first");
        rd(ADDR_DATA, w1, "echo second");
        chk("clock oe", !slv, bclk_oe);
        chk("sync oe", !slv, fs_oe);
        cod_run <= 1'b0;
        $display("test echo mode %h done", m);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_fail++;
        $display("mismatch watchdog expected done seen timeout");
        give_verdict;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_CTRL, 32'h00280000, "ctrl reset");
        rd(ADDR_MODE, MODE_RESET, "mode reset");
        wr(ADDR_MODE, MODE_WMASK);
        rd(ADDR_MODE, MODE_WMASK, "mode mask");
        rd(8'h0C, 32'h0, "unmapped read");
        chk("slverr", 32'h1, err);
        $display("test registers done");
        foreach (modes[i]) begin
            wr(ADDR_CTRL, 32'h0);
            wr(ADDR_MODE, modes[i]);
            wr(ADDR_CTRL, 32'h5);
            repeat (300) @(posedge clk);
            frame_length = modes[i][19:10];
            sync_pulse_width = modes[i][9:0];
            per = 2 * BCLK_HALF_CYCLES * (frame_length + 1);
            e_rise = (sync_pulse_width == 0 || sync_pulse_width >= frame_length) ? 0 : 1024 / per;
            e_on = (sync_pulse_width >= frame_length) ? 1024 : e_rise * per / (frame_length + 1) * sync_pulse_width;
            count_sync(~modes[i][20]);
            chk("sync onsets", e_rise, rise);
            chk("sync active", e_on, on);
        end
        chk("clock oe", 32'h1, bclk_oe);
        chk("sync oe", 32'h1, fs_oe);
        $display("test sync timing done");
        wr(ADDR_CTRL, 32'h1);
        repeat (300) @(posedge clk);
        wr(ADDR_MODE, 32'h10007C01);
        repeat (20) @(posedge clk);
        count_clk;
        chk("gated clock", 32'h0, on);
        wr(ADDR_MODE, 32'h00007C01);
        repeat (20) @(posedge clk);
        count_clk;
        chk("running clock", 32'h20, on);
        $display("test clock gate done");
        echo(32'h03007C01, 32'hBEEF1234, 32'h0F0F8001, 1'b0);
        echo(32'h00007C01, 32'h00001234, 32'h0000BEEF, 1'b0);
        echo(32'h03A07C01, 32'hCAFE5A5A, 32'h13572468, 1'b1);
        echo(32'h00407C01, 32'h0000A5C3, 32'h00003C5A, 1'b0);
        echo(32'h03B07C01, 32'h2468ACE0, 32'h11223344, 1'b1);
        echo(32'h04007C01, 32'h1, 32'h1, 1'b0);
        echo(32'h0D007C01, 32'h1, 32'h1, 1'b0);
        give_verdict;
    end
endmodule
`default_nettype wire
